//--- wwd_countdown.sv
// Loadable one-shot cycle timer with busy level and done pulse
`timescale 1ns/1ps
module wwd_countdown #(
	parameter int W = 13
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Control
	input wire logic start,
	input wire logic [W-1:0] load,
	// Status
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic last;

	// Count down while busy, reload on an idle start
	assign last = (cnt_q == W'(1));
	assign busy = (cnt_q != '0);
	assign done = busy && last;
	assign cnt_d = busy ? cnt_q - W'(1) : (start ? load : '0);

	// Remaining cycles
	always_ff @(posedge mclk) begin
		if (!rst_n) cnt_q <= '0;
		else cnt_q <= cnt_d;
	end

	a_busy_ends: assert property (@(posedge mclk) disable iff (!rst_n)
		done |=> !busy) else $error("timer still busy after done");

endmodule

//--- wwd_pkg.sv
// Shared constants and types for the window watchdog timer
package wwd_pkg;

	// Bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int CNT_W = 7;

	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_WIN = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_STS = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_MASK = 4'h3;

	// Field positions
	localparam int ACT_BIT = 7;
	localparam int TOP_BIT = 6;
	localparam int STS_TIMEOUT = 0;
	localparam int STS_WINDOW = 1;
	localparam int STS_SOFT = 2;
	localparam int STS_HALT = 3;
	localparam int STS_W = 4;

	// Reset values and counter rollover value
	localparam logic [CNT_W-1:0] CNT_RST = 7'h7F;
	localparam logic [CNT_W-1:0] WIN_RST = 7'h7F;
	localparam logic [STS_W-1:0] MASK_RST = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ROLL = 7'h40;

	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int PRESCALE_CYCLES = 16384;
	localparam int RST_PULSE_NS = 30000;
	localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 13;
	localparam logic [TMR_W-1:0] RST_PULSE_LOAD = TMR_W'(RST_PULSE_CYC);
	localparam logic [TMR_W-1:0] WAKE_SHORT = 13'h0100;
	localparam logic [TMR_W-1:0] WAKE_LONG = 13'h1000;

	// Halt tracking states
	typedef enum logic [3:0] {
		HS_RUN = 4'b0001,
		HS_LAST = 4'b0010,
		HS_FROZEN = 4'b0100,
		HS_WAKE = 4'b1000
	} wwd_halt_t;

endpackage

//--- wwd_prescaler.sv
// Free-running prescaler that emits one tick per period
`timescale 1ns/1ps
module wwd_prescaler #(
	parameter int PERIOD = 16384
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Tick out
	output logic tick
);
	localparam int W = $clog2(PERIOD);
	localparam logic [W-1:0] LAST = W'(PERIOD - 1);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	// Wrap at the last count
	assign tick = (cnt_q == LAST);
	assign cnt_d = tick ? '0 : cnt_q + W'(1);

	// Phase counter, never touched by register writes
	always_ff @(posedge mclk) begin
		if (!rst_n) cnt_q <= '0;
		else cnt_q <= cnt_d;
	end

	a_tick_spacing: assert property (@(posedge mclk) disable iff (!rst_n)
		tick |=> !tick) else $error("prescaler ticked twice in a row");

endmodule

//--- wwd_top.sv
// Window watchdog: counter, window check, activation, halt handling, reset pulse
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module wwd_top import wwd_pkg::*; #(
	parameter int PRESCALE = PRESCALE_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Option straps
	input wire logic hw_watchdog_opt,
	input wire logic halt_reset_option,
	input wire logic wake_delay_long,
	// CPU halt handshake
	input wire logic halt_req,
	input wire logic wake_irq,
	output logic halt_enter,
	output logic cpu_halted,
	// Reset and interrupt out
	output logic wd_reset_n,
	output logic irq
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] win_q;
	logic [CNT_W-1:0] win_d;
	logic act_q;
	logic act_d;
	logic [STS_W-1:0] sts_q;
	logic [STS_W-1:0] sts_d;
	logic [STS_W-1:0] mask_q;
	logic [STS_W-1:0] mask_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic halt_ack_q;
	wwd_halt_t hs_q;
	wwd_halt_t hs_d;

	logic tick;
	logic pulse_busy;
	logic wake_busy;
	logic wake_done;

	// Address decode
	logic wr_ctrl;
	logic wr_win;
	logic wr_sts;
	logic wr_mask;
	assign wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
	assign wr_win = reg_wr && (reg_addr == OFF_WIN);
	assign wr_sts = reg_wr && (reg_addr == OFF_STS);
	assign wr_mask = reg_wr && (reg_addr == OFF_MASK);

	// Activation: hardware mode forces active
	logic active;
	logic act_after;
	assign active = hw_watchdog_opt || act_q;
	assign act_after = active || reg_wdata[ACT_BIT];

	// Counting is allowed outside the frozen halt states
	logic count_en;
	logic step;
	assign count_en = (hs_q == HS_RUN) || (hs_q == HS_LAST);
	assign step = tick && count_en && !wr_ctrl;

	// Reset causes
	logic ev_timeout;
	logic ev_window;
	logic ev_soft;
	logic ev_halt;
	logic [STS_W-1:0] events;
	logic fire;
	assign ev_timeout = step && active && (cnt_q == CNT_ROLL);
	assign ev_window = wr_ctrl && act_after && (cnt_q > win_q);
	// Software is expected to keep the top bit set; a clear one means reset
	assign ev_soft = wr_ctrl && act_after && !reg_wdata[TOP_BIT];
	assign ev_halt = halt_req && (hs_q == HS_RUN) && active && halt_reset_option;
	assign events = {ev_halt, ev_soft, ev_window, ev_timeout};
	assign fire = |events;

	// Halt acceptance when no reset is taken instead
	logic halt_ok;
	assign halt_ok = halt_req && (hs_q == HS_RUN) && !ev_halt;

	// Counter next value: reload wins over a step, wrap below zero
	assign cnt_d = wr_ctrl ? reg_wdata[CNT_W-1:0] : (step ? cnt_q - CNT_W'(1) : cnt_q);
	// Low six bits set the number of steps before the top bit falls

	// Activate bit only ever sets, in either mode; only reset clears it
	assign act_d = act_q || (wr_ctrl && reg_wdata[ACT_BIT]);
	assign win_d = wr_win ? reg_wdata[CNT_W-1:0] : win_q;
	assign mask_d = wr_mask ? reg_wdata[STS_W-1:0] : mask_q;

	// Sticky status, a new event beats a write-one clear
	assign sts_d = (sts_q & ~(wr_sts ? reg_wdata[STS_W-1:0] : '0)) | events;

	// Read mux, unmapped offsets read zero
	logic [DATA_W-1:0] rd_mux;
	assign rd_mux = (reg_addr == OFF_CTRL) ? {active, cnt_q} :
		(reg_addr == OFF_WIN) ? {1'b0, win_q} :
		(reg_addr == OFF_STS) ? {{(DATA_W-STS_W){1'b0}}, sts_q} :
		(reg_addr == OFF_MASK) ? {{(DATA_W-STS_W){1'b0}}, mask_q} : '0;
	assign rdata_d = reg_rd ? rd_mux : '0;

	// Halt sequencing
	always_comb begin
		hs_d = hs_q;
		unique case (hs_q)
			HS_RUN: begin
				if (halt_ok) hs_d = HS_LAST;
			end
			HS_LAST: begin
				if (wake_irq) hs_d = HS_WAKE;
				else if (tick) hs_d = HS_FROZEN;
			end
			HS_FROZEN: begin
				if (wake_irq) hs_d = HS_WAKE;
			end
			HS_WAKE: begin
				if (wake_done) hs_d = HS_RUN;
			end
			default: hs_d = HS_RUN;
		endcase
	end

	// Counter and activation
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_q <= CNT_RST;
			act_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			act_q <= act_d;
		end
	end

	// Window, mask, status and read data
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			win_q <= WIN_RST;
			mask_q <= MASK_RST;
			sts_q <= '0;
			rdata_q <= '0;
		end else begin
			win_q <= win_d;
			mask_q <= mask_d;
			sts_q <= sts_d;
			rdata_q <= rdata_d;
		end
	end

	// Halt state and acknowledge
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hs_q <= HS_RUN;
			halt_ack_q <= 1'b0;
		end else begin
			hs_q <= hs_d;
			halt_ack_q <= halt_ok;
		end
	end

	// Prescaler runs on regardless of register traffic
	wwd_prescaler #(
		.PERIOD(PRESCALE)
	) u_presc (
		.mclk(mclk),
		.rst_n(rst_n),
		.tick(tick)
	);

	// Reset pulse timer
	wwd_countdown #(
		.W(TMR_W)
	) u_pulse (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(fire),
		.load(RST_PULSE_LOAD),
		.busy(pulse_busy),
		.done()
	);

	// Wake-up resume delay
	wwd_countdown #(
		.W(TMR_W)
	) u_wake (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(hs_q != HS_WAKE && hs_d == HS_WAKE),
		.load(wake_delay_long ? WAKE_LONG : WAKE_SHORT),
		.busy(wake_busy),
		.done(wake_done)
	);

	// Outputs
	assign reg_rdata = rdata_q;
	assign wd_reset_n = !pulse_busy;
	assign irq = |(sts_q & mask_q);
	assign halt_enter = halt_ack_q;
	assign cpu_halted = (hs_q != HS_RUN);

	// Length of the reset pulse, helper count
	logic [TMR_W-1:0] low_cnt_q;
	always_ff @(posedge mclk) begin
		if (!rst_n) low_cnt_q <= '0;
		else low_cnt_q <= pulse_busy ? low_cnt_q + TMR_W'(1) : '0;
	end

	a_pulse_length: assert property (@(posedge mclk) disable iff (!rst_n)
		low_cnt_q <= RST_PULSE_LOAD) else $error("reset pulse too long");

	a_pulse_full: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(wd_reset_n) |-> (low_cnt_q == RST_PULSE_LOAD))
		else $error("reset pulse released early");

	a_timeout_reset: assert property (@(posedge mclk) disable iff (!rst_n)
		(step && active && cnt_q == 7'h40) |=> !wd_reset_n ##1 !wd_reset_n)
		else $error("no reset on counter rollover");

	a_window_reset: assert property (@(posedge mclk) disable iff (!rst_n)
		(wr_ctrl && act_after && cnt_q > win_q) |=> !wd_reset_n && sts_q[STS_WINDOW])
		else $error("early reload did not reset");

	a_soft_reset: assert property (@(posedge mclk) disable iff (!rst_n)
		(wr_ctrl && reg_wdata[ACT_BIT] && !reg_wdata[TOP_BIT]) |=> !wd_reset_n)
		else $error("software reset missing");

	a_halt_reset: assert property (@(posedge mclk) disable iff (!rst_n)
		(halt_req && hs_q == HS_RUN && active && halt_reset_option)
		|=> !wd_reset_n && !cpu_halted && !halt_enter)
		else $error("halt not turned into reset");

	a_hw_active: assert property (@(posedge mclk) disable iff (!rst_n)
		(hw_watchdog_opt && reg_rd && reg_addr == OFF_CTRL) |=> reg_rdata[ACT_BIT])
		else $error("hardware mode not shown as active");

	a_act_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
		act_q |=> act_q) else $error("activate bit cleared without reset");

	a_counter_step: assert property (@(posedge mclk) disable iff (!rst_n)
		(tick && count_en && !wr_ctrl) |=> cnt_q == CNT_W'($past(cnt_q) - 7'h01))
		else $error("counter did not step down");

	a_counter_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		(hs_q == HS_FROZEN && !wr_ctrl) |=> $stable(cnt_q))
		else $error("frozen counter moved");

	a_reset_value: assert property (@(posedge mclk)
		!rst_n |=> cnt_q == 7'h7F && !act_q) else $error("bad control reset value");

	a_wake_resume: assert property (@(posedge mclk) disable iff (!rst_n)
		(hs_q == HS_WAKE && wake_done) |=> !cpu_halted)
		else $error("no resume after wake delay");

	a_wake_busy: assert property (@(posedge mclk) disable iff (!rst_n)
		(hs_q == HS_WAKE) |-> wake_busy)
		else $error("wake delay not running");

	a_frozen_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
		(hs_q == HS_FROZEN || hs_q == HS_WAKE) |-> !ev_timeout)
		else $error("timeout raised while halted");

	a_halt_grant: assert property (@(posedge mclk) disable iff (!rst_n)
		(halt_req && hs_q == HS_RUN && !(active && halt_reset_option))
		|=> halt_enter && cpu_halted)
		else $error("halt not granted");

	a_halt_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
		(halt_req && hs_q != HS_RUN) |=> !halt_enter)
		else $error("halt granted while halted");

	// Register port, status and interrupt
	a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == '0)
		else $error("read data outside read cycle");

	a_reload_wins: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_ctrl |=> cnt_q == CNT_W'($past(reg_wdata)))
		else $error("control write not loaded");

	a_status_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
		!wr_sts |=> (sts_q & $past(sts_q)) == $past(sts_q))
		else $error("status bit lost without clear");

	a_irq_follows: assert property (@(posedge mclk) disable iff (!rst_n)
		((|(events & mask_q)) && !wr_mask) |=> irq)
		else $error("unmasked event gave no interrupt");

	// Reset pulse start and quiet when disabled
	a_pulse_start: assert property (@(posedge mclk) disable iff (!rst_n)
		(fire && wd_reset_n) |=> !wd_reset_n)
		else $error("reset pulse did not start");

	a_idle_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
		(!active && !(wr_ctrl && reg_wdata[ACT_BIT]) && wd_reset_n) |=> wd_reset_n)
		else $error("reset while watchdog disabled");

endmodule

//--- wwd_top_bench.sv
// Self-checking bench for the window watchdog top
`timescale 1ns/1ps
module wwd_top_bench import wwd_pkg::*; ;
	localparam int PRE = 16;
	// Clock, reset and register port
	logic mclk, rst_n, reg_wr, reg_rd;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	// Straps, halt handshake and outputs
	logic hw_watchdog_opt, halt_reset_option, wake_delay_long, halt_req, wake_irq;
	logic halt_enter, cpu_halted, wd_reset_n, irq;
	int num_errors, num_checks;
	logic [7:0] a, b;

	wwd_top #(.PRESCALE(PRE)) wwd_top_inst (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.hw_watchdog_opt(hw_watchdog_opt), .halt_reset_option(halt_reset_option),
		.wake_delay_long(wake_delay_long), .halt_req(halt_req), .wake_irq(wake_irq),
		.halt_enter(halt_enter), .cpu_halted(cpu_halted), .wd_reset_n(wd_reset_n), .irq(irq));

	// Clock source
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task end_sim();
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task wr(input logic [ADDR_W-1:0] ad, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [ADDR_W-1:0] ad, output logic [7:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Reset held for eight cycles with the given straps
	task do_reset(input logic hw, input logic ho);
		@(posedge mclk);
		rst_n <= 1'b0;
		hw_watchdog_opt <= hw;
		halt_reset_option <= ho;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
	endtask

	// One-cycle halt request or wake interrupt
	task pulse_in(input logic wake);
		@(posedge mclk);
		if (wake) wake_irq <= 1'b1;
		else halt_req <= 1'b1;
		@(posedge mclk);
		halt_req <= 1'b0;
		wake_irq <= 1'b0;
	endtask

	// Latency to the reset pulse, its cause flag, interrupt masking and its length
	task pulse(input int lo, input int hi, input int sb);
		int w;
		int n;
		logic [7:0] d;
		w = 0;
		#1;
		while (wd_reset_n !== 1'b0 && w < 5000) begin
			@(posedge mclk);
			#1;
			w++;
		end
		chk("reset_latency", 8'(w >= lo && w <= hi), 8'h01);
		rd(OFF_STS, d);
		chk("status", d, 8'(1 << sb));
		chk("irq_masked", {7'h00, irq}, 8'h00);
		wr(OFF_MASK, 8'(1 << sb));
		#1;
		chk("irq_set", {7'h00, irq}, 8'h01);
		wr(OFF_STS, 8'hFF);
		#1;
		chk("irq_clear", {7'h00, irq}, 8'h00);
		n = 6;
		while (wd_reset_n === 1'b0 && n < 5000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("pulse_len", 8'(n == RST_PULSE_CYC), 8'h01);
	endtask

	// Hang guard
	initial begin
		#600000;
		num_errors++;
		end_sim();
	end

	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		hw_watchdog_opt = 1'b0;
		halt_reset_option = 1'b0;
		wake_delay_long = 1'b0;
		halt_req = 1'b0;
		wake_irq = 1'b0;
		num_errors = 0;
		num_checks = 0;
		// Reset values, unmapped offset, free-running count while disabled
		do_reset(1'b0, 1'b0);
		rd(OFF_CTRL, a);
		chk("ctrl_reset", a, 8'h7F);
		rd(OFF_WIN, a);
		chk("win_reset", a, 8'h7F);
		rd(OFF_MASK, a);
		chk("mask_reset", a, 8'h00);
		rd(4'hF, a);
		chk("unmapped", a, 8'h00);
		rd(OFF_CTRL, a);
		repeat (30) @(posedge mclk);
		rd(OFF_CTRL, b);
		chk("step_pair", a - b, 8'h02);
		// Disabled write outside the window, then the activating one
		wr(OFF_WIN, 8'h50);
		rd(OFF_WIN, a);
		chk("win_write", a, 8'h50);
		wr(OFF_CTRL, 8'h7F);
		repeat (3) @(posedge mclk);
		#1;
		chk("no_reset_off", {7'h00, wd_reset_n}, 8'h01);
		rd(OFF_CTRL, a);
		chk("still_off", {7'h00, a[ACT_BIT]}, 8'h00);
		wr(OFF_CTRL, 8'hFF);
		pulse(0, 0, STS_WINDOW);
		// Top bit cleared with activate set
		do_reset(1'b0, 1'b0);
		wr(OFF_CTRL, 8'hBF);
		pulse(0, 0, STS_SOFT);
		// Legal refresh inside the window, then timeout from 48h
		do_reset(1'b0, 1'b0);
		repeat (40) @(posedge mclk);
		wr(OFF_CTRL, 8'hC8);
		pulse(8 * PRE + 1, 9 * PRE, STS_TIMEOUT);
		// Hardware mode ignores the activate bit
		do_reset(1'b1, 1'b0);
		rd(OFF_CTRL, a);
		chk("hw_active", {7'h00, a[ACT_BIT]}, 8'h01);
		wr(OFF_CTRL, 8'h3F);
		pulse(0, 0, STS_SOFT);
		// Halt with the reset option while active
		do_reset(1'b1, 1'b1);
		pulse_in(1'b0);
		pulse(0, 0, STS_HALT);
		chk("no_halt", {7'h00, cpu_halted}, 8'h00);
		// Plain halt with both wake delays
		for (int lg = 0; lg < 2; lg++) begin
			do_reset(1'b0, 1'b0);
			wake_delay_long <= lg[0];
			wr(OFF_CTRL, 8'hFF);
			pulse_in(1'b0);
			#1;
			chk("halt_enter", {7'h00, halt_enter}, 8'h01);
			rd(OFF_CTRL, a);
			repeat (60) @(posedge mclk);
			rd(OFF_CTRL, b);
			chk("frozen", 8'((a - b) <= 8'h01), 8'h01);
			pulse_in(1'b1);
			repeat ((lg != 0 ? 4096 : 256) - 8) @(posedge mclk);
			#1;
			chk("still_halted", {7'h00, cpu_halted}, 8'h01);
			chk("halt_no_reset", {7'h00, wd_reset_n}, 8'h01);
			repeat (16) @(posedge mclk);
			#1;
			chk("resumed", {7'h00, cpu_halted}, 8'h00);
		end
		end_sim();
	end
endmodule
